/* File: bma_params.svh */
// address map, field positions and counts for the bignum accelerator controller
`ifndef BMA_PARAMS_SVH
`define BMA_PARAMS_SVH
`define BMA_DW                32
`define BMA_IW                8
// ---------------------------------------------------------------------
// accelerator registers
// ---------------------------------------------------------------------
`define BMA_REG_MPRIME        32'h3FF0_2800
`define BMA_REG_EXP_MODE      32'h3FF0_2804
`define BMA_REG_EXP_LAUNCH    32'h3FF0_2808
`define BMA_REG_MUL_MODE      32'h3FF0_280C
`define BMA_REG_MUL_LAUNCH    32'h3FF0_2810
`define BMA_REG_DONE_FLAG     32'h3FF0_2814
`define BMA_REG_INIT_STAT     32'h3FF0_2818
// ---------------------------------------------------------------------
// operand memories, 128 words each
// ---------------------------------------------------------------------
`define BMA_MEM_M_BASE        32'h3FF0_2000
`define BMA_MEM_Z_BASE        32'h3FF0_2200
`define BMA_MEM_Y_BASE        32'h3FF0_2400
`define BMA_MEM_X_BASE        32'h3FF0_2600
`define BMA_MEM_WORDS         8'h80
// ---------------------------------------------------------------------
// fields and values
// ---------------------------------------------------------------------
`define BMA_DONE_BIT          0
`define BMA_INIT_BIT          0
`define BMA_LAUNCH_VAL        32'h0000_0001
`define BMA_CLEAR_VAL         32'h0000_0001
`define BMA_MUL_PLAIN_OFS     32'h0000_0008
`define BMA_MODULAR_MAX_CODE  32'h0000_0007
`define BMA_PLAIN_MAX_CODE    3'h3
`define BMA_DIGIT_SH          4
`define BMA_WORD_SH           2
`endif

/* File: bma_pkg.sv */
// types shared by the bignum accelerator controller
`include "bma_params.svh"
package bma_pkg;
    typedef enum logic [1:0] {OP_MODEXP, OP_MODMULT, OP_MULT} bma_op_e;
    typedef enum logic [1:0] {MEM_X, MEM_Y, MEM_M, MEM_Z} bma_mem_e;
    typedef enum logic [1:0] {SRC_X, SRC_Y, SRC_M, SRC_RBAR} bma_src_e;
    typedef enum logic [3:0] {
        ST_OFF, ST_CLK, ST_INIT_RD, ST_INIT_WT, ST_IDLE, ST_MODE, ST_LOAD, ST_MPRIME,
        ST_START, ST_WAIT, ST_POLL_WT, ST_RES_RD, ST_RES_WT, ST_CLR
    } bma_state_e;
    typedef struct packed {
        bma_op_e              op;
        logic [2:0]           len_code;
        logic [`BMA_DW-1:0]   m_prime;
        logic                 wait_irq;
    } bma_cmd_s;
    typedef struct packed {
        logic                 req;
        logic                 we;
        logic [`BMA_DW-1:0]   addr;
        logic [`BMA_DW-1:0]   wdata;
    } bma_bus_s;
    typedef struct packed {
        logic                 valid;
        bma_src_e             src;
        logic [`BMA_IW-1:0]   idx;
    } bma_fetch_s;
    typedef struct packed {
        logic                 valid;
        logic [`BMA_IW-1:0]   idx;
        logic [`BMA_DW-1:0]   data;
    } bma_res_s;
    typedef struct packed {
        logic                 valid;
        logic                 error;
    } bma_done_s;
    typedef struct packed {
        bma_mem_e             mem;
        bma_src_e             src;
        logic                 user_lo;
        logic                 user_hi;
    } bma_step_s;
    typedef struct packed {
        bma_state_e           st;
        bma_cmd_s             cmd;
        logic                 round2;
        logic [1:0]           phase;
        logic                 gap;
        bma_bus_s             bus;
        bma_res_s             res;
        bma_done_s            done;
    } bma_host_s;
endpackage

/* File: bma_counter.sv */
// digit index counter with clear and increment
module bma_counter #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_b,
    // control
    input  wire logic         clr,
    input  wire logic         inc,
    // value
    output logic [W-1:0]      val
);
    logic [W-1:0] val_reg;
    logic [W-1:0] val_next;

    always_comb
    begin
        val_next = val_reg;
        if (clr)
            val_next = '0;
        else if (inc)
            val_next = val_reg + W'(1);
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            val_reg <= '0;
        else
            val_reg <= val_next;
    end

    assign val = val_reg;
endmodule

/* File: bma_host.sv */
// controller that runs the bignum accelerator through its register and memory map
`include "bma_params.svh"
// Contract
// - Poll init status until one before any write to the accelerator.
// - Write r-bar and M-prime before launching any modular operation.
// - All operands of one modular calculation share one length.
// - M-prime is always one full 32-bit word.
// - Exponentiation: mode, load X Y M r-bar, M-prime, then launch one.
// - Writing one to the done flag clears it, after each completion.
// - Modular multiplication runs as two launched rounds, each completing.
// - Round one loads X M r-bar; round two loads Y into X.
// - Plain multiply: X gets high zero digits, Y low zeros into Z.
// - Plain multiply mode is 2N/512 minus one plus eight; result in Z.
module bma_host
    import bma_pkg::*;
(
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    // user commands
    input  wire logic                 host_enable,
    input  wire logic                 cmd_valid,
    input  wire bma_cmd_s             cmd_in,
    output logic                      cmd_ready,
    output bma_done_s                 done_out,
    // operand fetch
    output bma_fetch_s                fetch_out,
    input  wire logic                 fetch_ready,
    input  wire logic [`BMA_DW-1:0]   fetch_data,
    // result words
    output bma_res_s                  res_out,
    // accelerator side
    output logic                      accel_clock_enable,
    output logic                      accel_power_down,
    output bma_bus_s                  dev_bus,
    input  wire logic [`BMA_DW-1:0]   dev_rdata,
    input  wire logic                 op_done_irq
);
    bma_host_s            q;
    bma_host_s            nx;
    bma_step_s            step;
    logic                 cnt_clr;
    logic                 cnt_inc;
    logic [`BMA_IW-1:0]   cnt_val;
    logic [`BMA_IW-1:0]   digits;
    logic [`BMA_IW-1:0]   words;
    logic                 lo_n;
    logic                 need_user;
    logic                 plain;
    logic                 last_phase;

    // ---------------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------------
    function automatic bma_bus_s wr(input logic [`BMA_DW-1:0] a, input logic [`BMA_DW-1:0] d);
        wr = '{req: 1'b1, we: 1'b1, addr: a, wdata: d};
    endfunction

    function automatic bma_bus_s rd(input logic [`BMA_DW-1:0] a);
        rd = '{req: 1'b1, we: 1'b0, addr: a, wdata: '0};
    endfunction

    function automatic logic [`BMA_DW-1:0] base_of(input bma_mem_e m);
        case (m)
            MEM_X:   base_of = `BMA_MEM_X_BASE;
            MEM_Y:   base_of = `BMA_MEM_Y_BASE;
            MEM_M:   base_of = `BMA_MEM_M_BASE;
            default: base_of = `BMA_MEM_Z_BASE;
        endcase
    endfunction

    // load order per operation and round
    function automatic bma_step_s step_of(input bma_op_e op, input logic r2,
                                          input logic [1:0] ph);
        step_of = '{mem: MEM_X, src: SRC_X, user_lo: 1'b1, user_hi: 1'b0};
        if (op == OP_MULT)
        begin
            if (ph != 2'd0)
                step_of = '{mem: MEM_Z, src: SRC_Y, user_lo: 1'b0, user_hi: 1'b1};
        end
        else if (op == OP_MODMULT && r2)
            step_of.src = SRC_Y;
        else
        begin
            case (ph)
                2'd0:    step_of.mem = MEM_X;
                2'd1:    step_of.mem = (op == OP_MODEXP) ? MEM_Y : MEM_M;
                2'd2:    step_of.mem = (op == OP_MODEXP) ? MEM_M : MEM_Z;
                default: step_of.mem = MEM_Z;
            endcase
            case (step_of.mem)
                MEM_Y:   step_of.src = SRC_Y;
                MEM_M:   step_of.src = SRC_M;
                MEM_Z:   step_of.src = SRC_RBAR;
                default: step_of.src = SRC_X;
            endcase
        end
    endfunction

    bma_counter #(
        .W (`BMA_IW)
    ) u_idx (
        .clock (clock),
        .rst_b (rst_b),
        .clr   (cnt_clr),
        .inc   (cnt_inc),
        .val   (cnt_val)
    );

    // ---------------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------------
    always_comb
    begin
        nx = q;
        nx.bus = '0;
        nx.res.valid = 1'b0;
        nx.done = '0;
        cnt_clr = 1'b0;
        cnt_inc = 1'b0;
        plain = (q.cmd.op == OP_MULT);
        step = step_of(q.cmd.op, q.round2, q.phase);
        digits = ({5'h00, q.cmd.len_code} + 8'h01) << `BMA_DIGIT_SH;
        words = plain ? (digits << 1) : digits;
        lo_n = (cnt_val < digits);
        need_user = (q.st == ST_LOAD) && (lo_n ? step.user_lo : step.user_hi);
        case (q.cmd.op)
            OP_MODEXP:  last_phase = (q.phase == 2'd3);
            OP_MODMULT: last_phase = q.round2 || (q.phase == 2'd2);
            default:    last_phase = (q.phase == 2'd1);
        endcase
        case (q.st)
            ST_OFF:
                if (host_enable)
                    nx.st = ST_CLK;
            ST_CLK:
                nx.st = ST_INIT_RD;
            ST_INIT_RD:
            begin
                nx.bus = rd(`BMA_REG_INIT_STAT);
                nx.gap = 1'b0;
                nx.st = ST_INIT_WT;
            end
            ST_INIT_WT:
                if (!q.gap)
                    nx.gap = 1'b1;
                else
                    nx.st = dev_rdata[`BMA_INIT_BIT] ? ST_IDLE : ST_INIT_RD;
            ST_IDLE:
                if (cmd_valid)
                begin
                    nx.cmd = cmd_in;
                    nx.round2 = 1'b0;
                    nx.phase = 2'd0;
                    cnt_clr = 1'b1;
                    if (cmd_in.op == OP_MULT && cmd_in.len_code > `BMA_PLAIN_MAX_CODE)
                    begin
                        nx.done.valid = 1'b1;
                        nx.done.error = 1'b1;
                    end
                    else
                        nx.st = ST_MODE;
                end
            ST_MODE:
            begin
                if (q.cmd.op == OP_MODEXP)
                    nx.bus = wr(`BMA_REG_EXP_MODE, 32'(q.cmd.len_code));
                else if (plain)
                    nx.bus = wr(`BMA_REG_MUL_MODE,
                                32'({q.cmd.len_code, 1'b1}) + `BMA_MUL_PLAIN_OFS);
                else
                    nx.bus = wr(`BMA_REG_MUL_MODE, 32'(q.cmd.len_code));
                nx.st = ST_LOAD;
            end
            ST_LOAD:
                if (!need_user || fetch_ready)
                begin
                    nx.bus = wr(base_of(step.mem) + (32'(cnt_val) << `BMA_WORD_SH),
                                need_user ? fetch_data : '0);
                    if (cnt_val == words - 8'h01)
                    begin
                        cnt_clr = 1'b1;
                        nx.phase = q.phase + 2'd1;
                        if (last_phase)
                        begin
                            nx.phase = 2'd0;
                            nx.st = (plain || q.round2) ? ST_START : ST_MPRIME;
                        end
                    end
                    else
                        cnt_inc = 1'b1;
                end
            ST_MPRIME:
            begin
                nx.bus = wr(`BMA_REG_MPRIME, q.cmd.m_prime);
                nx.st = ST_START;
            end
            ST_START:
            begin
                nx.bus = wr((q.cmd.op == OP_MODEXP) ? `BMA_REG_EXP_LAUNCH : `BMA_REG_MUL_LAUNCH,
                            `BMA_LAUNCH_VAL);
                nx.st = ST_WAIT;
            end
            ST_WAIT:
                if (!q.cmd.wait_irq || op_done_irq)
                begin
                    nx.bus = rd(`BMA_REG_DONE_FLAG);
                    nx.gap = 1'b0;
                    nx.st = ST_POLL_WT;
                end
            ST_POLL_WT:
                if (!q.gap)
                    nx.gap = 1'b1;
                else if (!dev_rdata[`BMA_DONE_BIT])
                    nx.st = ST_WAIT;
                else if (q.cmd.op == OP_MODMULT && !q.round2)
                    nx.st = ST_CLR;
                else
                begin
                    cnt_clr = 1'b1;
                    nx.st = ST_RES_RD;
                end
            ST_RES_RD:
            begin
                nx.bus = rd(`BMA_MEM_Z_BASE + (32'(cnt_val) << `BMA_WORD_SH));
                nx.gap = 1'b0;
                nx.st = ST_RES_WT;
            end
            ST_RES_WT:
                if (!q.gap)
                    nx.gap = 1'b1;
                else
                begin
                    nx.res = '{valid: 1'b1, idx: cnt_val, data: dev_rdata};
                    if (cnt_val == words - 8'h01)
                    begin
                        cnt_clr = 1'b1;
                        nx.st = ST_CLR;
                    end
                    else
                    begin
                        cnt_inc = 1'b1;
                        nx.st = ST_RES_RD;
                    end
                end
            ST_CLR:
            begin
                nx.bus = wr(`BMA_REG_DONE_FLAG, `BMA_CLEAR_VAL);
                if (q.cmd.op == OP_MODMULT && !q.round2)
                begin
                    nx.round2 = 1'b1;
                    nx.st = ST_LOAD;
                end
                else
                begin
                    nx.done.valid = 1'b1;
                    nx.st = ST_IDLE;
                end
            end
            default:
                nx.st = ST_OFF;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= nx;
    end

    assign cmd_ready          = (q.st == ST_IDLE);
    assign done_out           = q.done;
    assign res_out            = q.res;
    assign dev_bus            = q.bus;
    assign accel_clock_enable = (q.st != ST_OFF);
    assign accel_power_down   = (q.st == ST_OFF) || (q.st == ST_CLK);
    assign fetch_out.valid    = need_user;
    assign fetch_out.src      = step.src;
    assign fetch_out.idx      = lo_n ? cnt_val : cnt_val - digits;

    // ---------------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // read data stands only in the cycle after the request
    logic rd_init_d1, rd_flag_d1, init_ok, mp_ok;
    logic dev_wr;
    assign dev_wr = dev_bus.req && dev_bus.we;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_init_d1 <= 1'b0;
            rd_flag_d1 <= 1'b0;
            init_ok    <= 1'b0;
            mp_ok      <= 1'b0;
        end
        else
        begin
            rd_init_d1 <= dev_bus.req && !dev_bus.we && dev_bus.addr == `BMA_REG_INIT_STAT;
            rd_flag_d1 <= dev_bus.req && !dev_bus.we && dev_bus.addr == `BMA_REG_DONE_FLAG;
            init_ok    <= !accel_power_down && (init_ok || (rd_init_d1 && dev_rdata[`BMA_INIT_BIT]));
            mp_ok      <= !accel_power_down && (mp_ok || (dev_wr && dev_bus.addr == `BMA_REG_MPRIME));
        end
    end

    a_init_before_write: assert property (dev_wr |-> init_ok)
        else $error("accelerator written before init status read one");
    a_mprime_before_go: assert property (dev_wr && (dev_bus.addr == `BMA_REG_EXP_LAUNCH ||
        dev_bus.addr == `BMA_REG_MUL_LAUNCH) && q.cmd.op != OP_MULT |-> mp_ok)
        else $error("launch before M-prime written");
    a_launch_value: assert property (dev_wr && (dev_bus.addr == `BMA_REG_EXP_LAUNCH ||
        dev_bus.addr == `BMA_REG_MUL_LAUNCH) |-> dev_bus.wdata == `BMA_LAUNCH_VAL)
        else $error("launch register written with other than one");
    a_clear_value: assert property (dev_wr && dev_bus.addr == `BMA_REG_DONE_FLAG
        |-> dev_bus.wdata == `BMA_CLEAR_VAL)
        else $error("done flag written with other than one");
    a_exp_mode_val: assert property (dev_wr && dev_bus.addr == `BMA_REG_EXP_MODE
        |-> dev_bus.wdata <= `BMA_MODULAR_MAX_CODE ##1 q.st == ST_LOAD)
        else $error("bad exponent mode or no load after it");
    a_mul_mode_val: assert property (dev_wr && dev_bus.addr == `BMA_REG_MUL_MODE |->
        (q.cmd.op == OP_MULT) ? (dev_bus.wdata == 32'({q.cmd.len_code, 1'b1}) +
        `BMA_MUL_PLAIN_OFS) : (dev_bus.wdata == 32'(q.cmd.len_code)))
        else $error("multiply mode value wrong");
    a_mprime_value: assert property (dev_wr && dev_bus.addr == `BMA_REG_MPRIME
        |-> dev_bus.wdata == q.cmd.m_prime ##1 dev_wr)
        else $error("M-prime value wrong or launch not next");
    a_zero_digits: assert property (q.st == ST_LOAD && plain && !need_user && nx.bus.req
        |=> dev_bus.wdata == '0)
        else $error("padding digit not zero");
    a_clear_after_done: assert property (rd_flag_d1 && dev_rdata[`BMA_DONE_BIT] && q.gap
        |-> ##[1:600] (dev_wr && dev_bus.addr == `BMA_REG_DONE_FLAG))
        else $error("completion not cleared in time");
    a_two_rounds: assert property (q.st == ST_CLR && q.cmd.op == OP_MODMULT && !q.round2
        |=> q.round2 && q.st == ST_LOAD && fetch_out.src == SRC_Y)
        else $error("second round not started with Y");
endmodule

/* File: bma_dev_model.sv */
// behavioural model of the bignum accelerator behind the controller
`include "bma_params.svh"
module bma_dev_model
    import bma_pkg::*;
(
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst_b,
    // controller side
    input  wire logic               accel_clock_enable,
    input  wire logic               accel_power_down,
    input  wire bma_bus_s           dev_bus,
    output logic [`BMA_DW-1:0]      dev_rdata,
    output logic                    op_done_irq,
    // sticky misuse flag
    output logic                    misuse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [4][128];
    logic [31:0] mp, e_mode, m_mode, v;
    logic        clean, mp_ok, flag, bad;
    int          clr, busy, n, kind;
    bma_bus_s    b;
    assign b = dev_bus;
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b || accel_power_down)
        begin
            {clean, mp_ok, flag, clr, busy} = '0;
            bad = rst_b && (bad || b.req);
            misuse <= bad;
            op_done_irq <= 1'b0;
            dev_rdata <= 32'h5A5A_A5A5;
        end
        else
        begin
            bad = bad || !accel_clock_enable;
            if (!clean)
            begin
                for (int k = 0; k < 4; k++)
                    mem[k][clr] = 32'h0;
                clr++;
                clean = (clr == 128);
            end
            if (busy == 1)
            begin
                for (int i = 0; i < n; i++)
                begin
                    if (kind == 1)
                    begin
                        mem[1][i] = mem[3][i] ^ mem[2][i] ^ mem[0][i] ^ mem[1][i] ^ mp;
                        mem[3][i] = ~mem[3][i];
                    end
                    else if (kind == 2)
                        mem[1][i] = (mem[3][i] + mem[1][i]) ^ mem[0][i] ^ mp;
                    else
                    begin
                        mem[1][i] = mem[3][i] ^ mem[1][i];
                        mem[0][i] = ~mem[0][i];
                    end
                end
                flag = 1'b1;
            end
            if (busy != 0)
                busy--;
            // lone write path; launches ignore anything but one
            if (b.req && b.we && (!clean || busy != 0))
                bad = 1'b1;
            else if (b.req && b.we && !b.addr[11])
                mem[b.addr[10:9]][b.addr[8:2]] = b.wdata;
            else if (b.req && b.we)
                case (b.addr[4:2])
                    3'h0: {mp_ok, mp} = {1'b1, b.wdata};
                    3'h1: e_mode = b.wdata;
                    3'h3: m_mode = b.wdata;
                    3'h5: flag = flag && !b.wdata[0];
                    3'h2, 3'h4:
                    if (b.wdata == 32'h1)
                    begin
                        kind = b.addr[3] ? 1 : (m_mode[3] ? 3 : 2);
                        n = ((b.addr[3] ? e_mode[2:0] : m_mode[2:0]) + 1) * 16;
                        bad = bad || (kind != 3 && !mp_ok);
                        busy = 4 + $urandom_range(0, 40);
                    end
                    default: ;
                endcase
            case (b.addr[4:2])
                3'h0: v = mp;
                3'h1: v = e_mode;
                3'h3: v = m_mode;
                3'h5: v = {31'h0, flag};
                3'h6: v = {31'h0, clean};
                default: v = 32'h0;
            endcase
            if (b.req && !b.we)
                dev_rdata <= b.addr[11] ? v : mem[b.addr[10:9]][b.addr[8:2]];
            else
                dev_rdata <= ~dev_rdata;
            op_done_irq <= flag;
            misuse <= bad;
        end
    end
endmodule

/* File: tb_bma_host.sv */
// self-checking bench for the bignum accelerator controller
`include "bma_params.svh"
module tb_bma_host
    import bma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst_b, host_enable, cmd_valid, fetch_ready, cmd_ready;
    logic        accel_clock_enable, accel_power_down, op_done_irq, misuse;
    logic [31:0] fetch_data, dev_rdata, xv[128], yv[128], mv[128], rv[128];
    logic [40:0] got, exp_q[$];
    bma_cmd_s    cmd_in;
    bma_done_s   done_out;
    bma_fetch_s  fetch_out;
    bma_res_s    res_out;
    bma_bus_s    dev_bus;
    int          failures = 0, num_checks = 0, dones = 0;

    bma_host dut (.clock, .rst_b, .host_enable, .cmd_valid, .cmd_in, .cmd_ready, .done_out,
        .fetch_out, .fetch_ready, .fetch_data, .res_out, .accel_clock_enable,
        .accel_power_down, .dev_bus, .dev_rdata, .op_done_irq);
    bma_dev_model dev (.clock, .rst_b, .accel_clock_enable, .accel_power_down, .dev_bus,
        .dev_rdata, .op_done_irq, .misuse);

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always_comb
    begin
        case (fetch_out.src)
            SRC_X: fetch_data = xv[fetch_out.idx[6:0]];
            SRC_Y: fetch_data = yv[fetch_out.idx[6:0]];
            SRC_M: fetch_data = mv[fetch_out.idx[6:0]];
            default: fetch_data = rv[fetch_out.idx[6:0]];
        endcase
    end

    // operand source stalls at random
    always @(negedge clock)
        fetch_ready <= ($urandom_range(0, 3) != 0);

    // oldest note against each result or completion
    always @(negedge clock)
    begin
        got = done_out.valid ? {9'h100, 31'h0, done_out.error} : {1'b0, res_out.idx, res_out.data};
        if (res_out.valid === 1'b1 || done_out.valid === 1'b1)
        begin
            num_checks++;
            if (exp_q.size() == 0 || exp_q[0] !== got)
                err("result mismatch");
            if (exp_q.size() != 0)
                exp_q.delete(0);
            dones += (done_out.valid === 1'b1);
        end
    end

    task automatic err(input string s);
        failures++;
        $display("Error at %0t: %s", $time, s);
    endtask

    task automatic check(input logic ok, input string s);
        num_checks++;
        if (ok !== 1'b1)
            err(s);
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic run_cmd(input bma_op_e op, input logic [2:0] len);
        int n, c, tgt;
        logic [31:0] mp, z;
        n = 16 * (len + 1);
        tgt = dones + 1;
        mp = $urandom;
        foreach (xv[i])
        begin
            xv[i] = $urandom;
            yv[i] = $urandom;
            mv[i] = $urandom;
            rv[i] = $urandom;
        end
        for (int k = 0; k < 2 * n; k++)
        begin
            if (op == OP_MODEXP)
                z = xv[k] ^ yv[k] ^ mv[k] ^ rv[k] ^ mp;
            else if (op == OP_MODMULT)
                z = (yv[k] + ((xv[k] + rv[k]) ^ mv[k] ^ mp)) ^ mv[k] ^ mp;
            else
                z = (k < n) ? xv[k] : yv[k - n];
            if ((k < n || op == OP_MULT) && !(op == OP_MULT && len > 3))
                exp_q.push_back({1'b0, k[7:0], z});
        end
        exp_q.push_back({9'h100, 31'h0, op == OP_MULT && len > 3});
        @(negedge clock);
        cmd_in = '{op, len, mp, 1'($urandom)};
        cmd_valid = 1'b1;
        for (c = 0; c < 9999 && cmd_ready !== 1'b1; c++)
            @(negedge clock);
        if (cmd_ready !== 1'b1)
            err("command not taken");
        @(negedge clock);
        cmd_valid = 1'b0;
        for (int w = 0; w < 40000 && dones < tgt; w++)
            @(negedge clock);
        if (dones < tgt)
        begin
            err("no completion");
            end_sim();
        end
    endtask

    initial
    begin
        void'($urandom(32'hD2F5));
        rst_b = 1'b0;
        host_enable = 1'b0;
        cmd_valid = 1'b0;
        cmd_in = '0;
        fetch_ready = 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        repeat (6) @(negedge clock);
        check(accel_power_down === 1'b1 && cmd_ready === 1'b0, "left power-down");
        host_enable = 1'b1;
        for (int c = 0; c < 999 && cmd_ready !== 1'b1; c++)
            @(negedge clock);
        check(dev.clean === 1'b1 && accel_power_down === 1'b0 && cmd_ready === 1'b1,
              "ready too early or never");
        for (int l = 0; l < 8; l++)
        begin
            run_cmd(OP_MODEXP, l[2:0]);
            run_cmd(OP_MODMULT, l[2:0]);
        end
        for (int l = 0; l < 5; l++)
            run_cmd(OP_MULT, l[2:0]);
        check(misuse === 1'b0 && exp_q.size() == 0, "device misused");
        end_sim();
    end
endmodule
